/* hdl/sid_split_intr.sv */
// Local design decisions: the APB register port and the register addresses.
`default_nettype none
module sid_split_intr #(
    parameter int UFRAME_CYCLES = sid_pkg::UFRAME_CYCLES
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // packet request toward the schedule engine
    output logic TXN_REQ_O,
    output var sid_pkg::sid_txn_s TXN_O,
    output logic TXN_LOW_SPEED_O,
    input wire logic TXN_DONE_I,
    input wire logic [10:0] TXN_BYTES_I,
    input wire logic TXN_FATAL_I,
    // interrupt
    output logic IRQ_O
);
    // register state
    logic [63:0] desc_reg, desc_next;
    logic [7:0] poll_reg, poll_next;
    logic active_reg, active_next;
    logic [sid_pkg::EV_W-1:0] int_stat_reg, int_stat_next;
    logic [sid_pkg::EV_W-1:0] int_mask_reg, int_mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic err_reg, err_next;
    // sequencer state
    sid_pkg::sid_state_e state_reg, state_next;
    logic [14:0] remain_reg, remain_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic [8:0] poll_cnt_reg, poll_cnt_next;
    sid_pkg::sid_txn_s txn_reg, txn_next;
    // shared decode
    logic wr_acc, setup, busy, mapped, start, uframe_tick;
    logic end_ok, end_fatal, pkt_done;
    logic [1:0] kind, token;
    logic [14:0] total_len;
    logic [10:0] pkt_limit, pkt_len;

    // field decode; reserved bits 47, 30:29, 2:1 are never looked at
    assign kind = desc_reg[sid_pkg::KIND_LSB +: 2];
    assign token = desc_reg[sid_pkg::TOKEN_LSB +: 2];
    assign total_len = desc_reg[sid_pkg::LEN_LSB +: 15];
    assign pkt_limit = desc_reg[sid_pkg::PKT_LIM_LSB +: 11];
    assign busy = (state_reg != sid_pkg::ST_IDLE);
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && !err_reg;
    assign mapped = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= sid_pkg::ADDR_INT_MASK);
    // software starts by writing the active flag while valid is set
    assign start = wr_acc && (PADDR_I == sid_pkg::ADDR_CTRL) && PWDATA_I[0] && !busy
        && desc_reg[sid_pkg::VALID_BIT];
    assign pkt_done = (state_reg == sid_pkg::ST_REQ) && TXN_DONE_I;

    // next packet: remaining bytes capped at the packet size limit
    assign pkt_len = (remain_reg > {4'h0, pkt_limit}) ? pkt_limit : remain_reg[10:0];

    // end of descriptor: bad kind/token/length, engine fatal, a short packet, or all moved
    always_comb begin
        end_fatal = 1'b0;
        end_ok = 1'b0;
        if (pkt_done && TXN_FATAL_I) begin
            end_fatal = 1'b1;
        end else if (pkt_done) begin
            end_ok = (remain_reg <= {4'h0, TXN_BYTES_I}) || (TXN_BYTES_I < txn_reg.length);
        end else if (start) begin
            end_fatal = (kind != sid_pkg::KIND_INTERRUPT)
                || (token != sid_pkg::TOKEN_OUT && token != sid_pkg::TOKEN_IN)
                || (total_len > sid_pkg::MAX_TOTAL_BYTES);
        end
    end

    // microframe enable from a free-running divider
    assign uframe_tick = (tick_cnt_reg == 16'(UFRAME_CYCLES - 1));

    // register file next values; descriptor writes refused while busy
    always_comb begin
        desc_next = desc_reg;
        poll_next = poll_reg;
        active_next = active_reg;
        int_mask_next = int_mask_reg;
        int_stat_next = int_stat_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup) begin
            err_next = !mapped;
            case (PADDR_I)
                sid_pkg::ADDR_DESC_LO: rdata_next = desc_reg[31:0];
                sid_pkg::ADDR_DESC_HI: rdata_next = desc_reg[63:32];
                sid_pkg::ADDR_POLL: rdata_next = {24'h0, poll_reg};
                sid_pkg::ADDR_CTRL: rdata_next = {31'h0, active_reg};
                sid_pkg::ADDR_STATUS: rdata_next = {15'h0, remain_reg, state_reg};
                sid_pkg::ADDR_INT_STAT: rdata_next = {29'h0, int_stat_reg};
                sid_pkg::ADDR_INT_MASK: rdata_next = {29'h0, int_mask_reg};
                default: rdata_next = 32'h0;
            endcase
        end
        if (wr_acc && !busy) begin
            case (PADDR_I)
                sid_pkg::ADDR_DESC_LO: desc_next[31:0] = PWDATA_I;
                sid_pkg::ADDR_DESC_HI: desc_next[63:32] = PWDATA_I;
                sid_pkg::ADDR_POLL: poll_next = PWDATA_I[7:0];
                sid_pkg::ADDR_CTRL: active_next = PWDATA_I[0];
                default: ;
            endcase
        end
        if (wr_acc && PADDR_I == sid_pkg::ADDR_INT_MASK) begin
            int_mask_next = PWDATA_I[sid_pkg::EV_W-1:0];
        end
        // write one to clear; a new event in the same cycle wins
        if (wr_acc && PADDR_I == sid_pkg::ADDR_INT_STAT) begin
            int_stat_next = int_stat_reg & ~PWDATA_I[sid_pkg::EV_W-1:0];
        end
        if (end_ok) begin
            int_stat_next[sid_pkg::EV_DONE] = 1'b1;
        end
        if (end_fatal) begin
            int_stat_next[sid_pkg::EV_FATAL] = 1'b1;
        end
        if (pkt_done && !TXN_FATAL_I) begin
            int_stat_next[sid_pkg::EV_PACKET] = 1'b1;
        end
        // hardware retires the descriptor
        if (end_ok || end_fatal) begin
            desc_next[sid_pkg::VALID_BIT] = 1'b0;
            active_next = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            desc_reg <= sid_pkg::DESC_RST;
            poll_reg <= sid_pkg::POLL_RST;
            active_reg <= 1'b0;
            int_stat_reg <= '0;
            int_mask_reg <= sid_pkg::MASK_RST;
            rdata_reg <= 32'h0;
            err_reg <= 1'b0;
        end else begin
            desc_reg <= desc_next;
            poll_reg <= poll_next;
            active_reg <= active_next;
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    // sequencer next values
    always_comb begin
        state_next = state_reg;
        remain_next = remain_reg;
        poll_cnt_next = poll_cnt_reg;
        txn_next = txn_reg;
        tick_cnt_next = uframe_tick ? 16'h0 : tick_cnt_reg + 16'h1;
        case (state_reg)
            sid_pkg::ST_IDLE: begin
                if (start && !end_fatal) begin
                    remain_next = total_len;
                    poll_cnt_next = 9'h0; // first packet at the next microframe
                    state_next = sid_pkg::ST_WAIT;
                end
            end
            sid_pkg::ST_WAIT: begin
                if (uframe_tick && poll_cnt_reg == 9'h0) begin
                    // reload the interval: 2^(b-1) microframes
                    poll_cnt_next = sid_pkg::poll_interval(
                        poll_reg[sid_pkg::POLL_CODE_LSB +: 5]);
                    txn_next.split = desc_reg[sid_pkg::SPLIT_BIT];
                    txn_next.hub_port_index = desc_reg[sid_pkg::HUB_PORT_LSB +: 7];
                    // qualifier only meaningful for split, zero otherwise
                    txn_next.speed_endpoint_qualifier = desc_reg[sid_pkg::SPLIT_BIT]
                        ? desc_reg[sid_pkg::QUAL_LSB +: 2] : 2'b00;
                    txn_next.token_in = (token == sid_pkg::TOKEN_IN);
                    txn_next.function_addr = desc_reg[sid_pkg::ADDR_LSB +: 7];
                    txn_next.endpoint_number = {desc_reg[sid_pkg::ENDP_HI_LSB +: 3],
                        desc_reg[sid_pkg::ENDP_LO_BIT]};
                    txn_next.length = pkt_len;
                    state_next = sid_pkg::ST_REQ;
                end else if (uframe_tick) begin
                    poll_cnt_next = poll_cnt_reg - 9'h1;
                end
            end
            sid_pkg::ST_REQ: begin
                if (uframe_tick && poll_cnt_reg != 9'h0) begin
                    poll_cnt_next = poll_cnt_reg - 9'h1;
                end
                if (pkt_done) begin
                    remain_next = (remain_reg > {4'h0, TXN_BYTES_I})
                        ? remain_reg - {4'h0, TXN_BYTES_I} : 15'h0;
                    state_next = (end_ok || end_fatal) ? sid_pkg::ST_IDLE
                        : sid_pkg::ST_WAIT;
                end
            end
            default: state_next = sid_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg <= sid_pkg::ST_IDLE;
            remain_reg <= 15'h0;
            tick_cnt_reg <= 16'h0;
            poll_cnt_reg <= 9'h0;
            txn_reg <= '0;
        end else begin
            state_reg <= state_next;
            remain_reg <= remain_next;
            tick_cnt_reg <= tick_cnt_next;
            poll_cnt_reg <= poll_cnt_next;
            txn_reg <= txn_next;
        end
    end

    // outputs; apb always answers in the access cycle
    assign PRDATA_O = rdata_reg;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && err_reg;
    assign TXN_REQ_O = (state_reg == sid_pkg::ST_REQ);
    assign TXN_O = txn_reg;
    // low-speed only from a split with qualifier 10; 00 means full-speed
    assign TXN_LOW_SPEED_O = txn_reg.split
        && (txn_reg.speed_endpoint_qualifier == 2'b10);
    assign IRQ_O = |(int_stat_reg & int_mask_reg);

    // checker helper: cycles since the previous request of this descriptor
    logic [23:0] gap_cnt_reg, gap_cnt_next;
    logic seen_req_reg, seen_req_next;
    logic req_entry;
    assign req_entry = (state_reg == sid_pkg::ST_WAIT) && (state_next == sid_pkg::ST_REQ);

    // saturates, so a long idle spell never wraps into a false short gap
    always_comb begin
        gap_cnt_next = (gap_cnt_reg == 24'hFFFFFF) ? gap_cnt_reg : gap_cnt_reg + 24'h1;
        seen_req_next = seen_req_reg;
        if (start) begin
            seen_req_next = 1'b0; // first packet has no predecessor
        end
        if (req_entry) begin
            gap_cnt_next = 24'h0;
            seen_req_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gap_cnt_reg <= 24'h0;
            seen_req_reg <= 1'b0;
        end else begin
            gap_cnt_reg <= gap_cnt_next;
            seen_req_reg <= seen_req_next;
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_PORT_MAP: assert property ($rose(TXN_REQ_O) |->
        TXN_O.hub_port_index == desc_reg[56:50])
        else $error("hub port mismatch");
    AST_QUAL_HS: assert property (TXN_REQ_O && !TXN_O.split |->
        TXN_O.speed_endpoint_qualifier == 2'b00)
        else $error("qualifier used in high-speed");
    AST_SPLIT_SEL: assert property ($rose(TXN_REQ_O) |-> TXN_O.split == desc_reg[46])
        else $error("split select mismatch");
    AST_TOKEN: assert property ($rose(TXN_REQ_O) |->
        TXN_O.token_in == (desc_reg[43:42] == 2'b01))
        else $error("token mismatch");
    AST_ADDR: assert property ($rose(TXN_REQ_O) |->
        TXN_O.function_addr == desc_reg[41:35])
        else $error("address mismatch");
    AST_ENDP: assert property ($rose(TXN_REQ_O) |->
        TXN_O.endpoint_number == {desc_reg[34:32], desc_reg[31]})
        else $error("endpoint mismatch");
    AST_PKT_LIMIT: assert property (TXN_REQ_O |-> TXN_O.length <= desc_reg[28:18])
        else $error("packet exceeds limit");
    AST_VALID_CLR: assert property (pkt_done && TXN_FATAL_I |=>
        !desc_reg[0] && !active_reg && state_reg == sid_pkg::ST_IDLE)
        else $error("valid not cleared on fatal");
    AST_SPACING: assert property ($fell(TXN_REQ_O) && state_reg == sid_pkg::ST_WAIT
        && poll_reg[7:3] == 5'h01 |-> !TXN_REQ_O [*8])
        else $error("poll interval too short");
    AST_LOW_SPEED: assert property (TXN_LOW_SPEED_O |->
        TXN_O.split && TXN_O.speed_endpoint_qualifier == 2'b10)
        else $error("low-speed flag wrong");
    AST_REFUSE: assert property (start && end_fatal |=>
        !desc_reg[0] && int_stat_reg[sid_pkg::EV_FATAL] && state_reg == sid_pkg::ST_IDLE)
        else $error("bad descriptor not refused");
    AST_DONE_CLR: assert property (end_ok |=>
        !desc_reg[0] && !active_reg && int_stat_reg[sid_pkg::EV_DONE]
        && state_reg == sid_pkg::ST_IDLE)
        else $error("valid not cleared on completion");
    AST_GAP: assert property (req_entry && seen_req_reg |->
        gap_cnt_reg >= 24'((int'(sid_pkg::poll_interval(poll_reg[7:3])) + 1) * UFRAME_CYCLES - 1))
        else $error("packet requests closer than the polling interval");
endmodule : sid_split_intr
`default_nettype wire

/* hdl/sid_pkg.sv */
`default_nettype none
package sid_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0] ADDR_DESC_LO = 8'h00;
    localparam logic [7:0] ADDR_DESC_HI = 8'h04;
    localparam logic [7:0] ADDR_POLL = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    // field positions inside the 64-bit descriptor word
    localparam int HUB_PORT_LSB = 50;
    localparam int QUAL_LSB = 48;
    localparam int SPLIT_BIT = 46;
    localparam int KIND_LSB = 44;
    localparam int TOKEN_LSB = 42;
    localparam int ADDR_LSB = 35;
    localparam int ENDP_HI_LSB = 32;
    localparam int ENDP_LO_BIT = 31;
    localparam int PKT_LIM_LSB = 18;
    localparam int LEN_LSB = 3;
    localparam int VALID_BIT = 0;
    localparam int POLL_CODE_LSB = 3;
    // field encodings
    localparam logic [1:0] KIND_INTERRUPT = 2'h3;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN = 2'h1;
    // interrupt status bit positions
    localparam int EV_DONE = 0;
    localparam int EV_FATAL = 1;
    localparam int EV_PACKET = 2;
    localparam int EV_W = 3;
    // reset values
    localparam logic [63:0] DESC_RST = 64'h0;
    localparam logic [7:0] POLL_RST = 8'h00;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // timing: one microframe, and the largest total per descriptor
    localparam int UFRAME_NS = 125000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int UFRAME_CYCLES = UFRAME_NS / CLK_PERIOD_NS;
    localparam logic [14:0] MAX_TOTAL_BYTES = 15'h1000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_REQ = 2'b10
    } sid_state_e;

    // one packet request toward the translator side
    typedef struct packed {
        logic split;
        logic [6:0] hub_port_index;
        logic [1:0] speed_endpoint_qualifier;
        logic token_in;
        logic [6:0] function_addr;
        logic [3:0] endpoint_number;
        logic [10:0] length;
    } sid_txn_s;

    // polling code to interval minus one, in microframes (2^(b-1) - 1)
    function automatic logic [8:0] poll_interval(input logic [4:0] code);
        casez (code)
            5'b1????: poll_interval = 9'h0FF;
            5'b01???: poll_interval = 9'h07F;
            5'b001??: poll_interval = 9'h03F;
            5'b0001?: poll_interval = 9'h01F;
            5'b00001: poll_interval = 9'h00F;
            default: poll_interval = 9'h007;
        endcase
    endfunction : poll_interval
endpackage : sid_pkg
`default_nettype wire

/* testbench/sid_engine_model.sv */
`default_nettype none
module sid_eng_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // packet request from the block
    input wire logic req_i,
    input wire sid_pkg::sid_txn_s txn_i,
    input wire logic fatal_mode_i,
    // completion back to the block
    output logic done_o,
    output logic [10:0] bytes_o,
    output logic fatal_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;

    // answer three cycles after a request; result lines scrambled once the pulse is over
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_cnt <= 2'h0;
            done_o <= 1'b0;
            bytes_o <= 11'h000;
            fatal_o <= 1'b0;
        end else if (req_i && !done_o && wait_cnt == 2'h2) begin
            wait_cnt <= 2'h0;
            done_o <= 1'b1;
            bytes_o <= txn_i.length;
            fatal_o <= fatal_mode_i;
        end else begin
            wait_cnt <= (req_i && !done_o) ? wait_cnt + 2'h1 : 2'h0;
            done_o <= 1'b0;
            bytes_o <= ~bytes_o; // stale data must not look like a count
            fatal_o <= ~fatal_o;
        end
    end
endmodule : sid_eng_model
`default_nettype wire

/* testbench/sid_split_intr_tb_top.sv */
`default_nettype none
module sid_split_intr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fatal_mode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, req, lows, done, tfatal, irq, err;
    logic [10:0] bytes;
    sid_pkg::sid_txn_s txn;
    int errors = 0, check_count = 0, cyc = 0, t0, t1;
    logic [63:0] d;
    // one code per rate band except the 16-microframe band, low poll bits ones only in the first; interval in microframes
    logic [7:0] pcode [5] = '{8'h07, 8'h18, 8'h20, 8'h78, 8'h80};
    int ufr [5] = '{8, 32, 64, 128, 256};

    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    sid_split_intr #(.UFRAME_CYCLES(8)) dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .TXN_REQ_O(req), .TXN_O(txn),
        .TXN_LOW_SPEED_O(lows), .TXN_DONE_I(done), .TXN_BYTES_I(bytes), .TXN_FATAL_I(tfatal),
        .IRQ_O(irq));
    sid_eng_model eng_u (.clk_i(clk), .rst_i(rst), .req_i(req), .txn_i(txn),
        .fatal_mode_i(fatal_mode), .done_o(done), .bytes_o(bytes), .fatal_o(tfatal));

    task automatic give_verdict;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk

    // bounded wait for the request line to reach a level; stamps the cycle
    task automatic wait_req(input logic lvl, output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (req !== lvl && n < 4000);
        if (n >= 4000) chk("req_wait", 64'h1, 64'h0);
        t = cyc;
    endtask : wait_req

    function automatic logic [63:0] desc(input logic sp, input logic [1:0] q, input logic [1:0] k,
        input logic [1:0] tk, input logic [10:0] lim, input logic [14:0] len);
        // reserved positions are deliberately set to ones
        desc = {7'h00, 7'h55, q, 1'b1, sp, k, tk, 7'h2A, 3'h5, 1'b1, 2'h3, lim, len, 2'h3, 1'b1};
    endfunction : desc

    // load, arm and start one descriptor
    task automatic start(input logic [63:0] dv, input logic [7:0] poll);
        apb(1'b1, sid_pkg::ADDR_DESC_LO, dv[31:0]);
        apb(1'b1, sid_pkg::ADDR_DESC_HI, dv[63:32]);
        apb(1'b1, sid_pkg::ADDR_POLL, poll);
        apb(1'b1, sid_pkg::ADDR_CTRL, 32'h1);
    endtask : start

    task automatic finish_chk(input logic [31:0] ev);
        repeat (3) @(posedge clk);
        rchk("int_stat", sid_pkg::ADDR_INT_STAT, ev);
        rchk("desc_valid", sid_pkg::ADDR_DESC_LO, {d[31:1], 1'b0});
        rchk("ctrl_active", sid_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, sid_pkg::ADDR_INT_STAT, 32'h7);
        rchk("int_clear", sid_pkg::ADDR_INT_STAT, 32'h0);
    endtask : finish_chk

    initial begin
        #300000;
        errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk("desc_rst", sid_pkg::ADDR_DESC_LO, 32'h0);
        rchk("mask_rst", sid_pkg::ADDR_INT_MASK, 32'h0);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("slverr", 64'h1, {63'h0, err});
        // split, low speed, IN; three packets of 8, 8, 4 at a 16-microframe rate
        apb(1'b1, sid_pkg::ADDR_INT_MASK, 32'h7);
        d = desc(1'b1, 2'h2, 2'h3, 2'h1, 11'h008, 15'h0014);
        start(d, 8'h08);
        wait_req(1'b1, t0);
        chk("txn_split", {1'b1, 7'h55, 2'h2, 1'b1, 7'h2A, 4'hB, 11'h008}, txn);
        chk("low_speed", 64'h1, lows);
        wait_req(1'b0, t1);
        wait_req(1'b1, t1);
        chk("interval", 64'd128, t1 - t0);
        wait_req(1'b0, t1);
        wait_req(1'b1, t1);
        chk("last_len", 64'h4, txn.length);
        wait_req(1'b0, t1);
        chk("irq", 64'h1, irq);
        finish_chk(32'h5);
        // high speed OUT, qualifier ignored, zero length, irq masked
        apb(1'b1, sid_pkg::ADDR_INT_MASK, 32'h0);
        d = desc(1'b0, 2'h3, 2'h3, 2'h0, 11'h040, 15'h0000);
        start(d, 8'h00);
        wait_req(1'b1, t0);
        chk("txn_hs", {1'b0, 7'h55, 2'h0, 1'b0, 7'h2A, 4'hB, 11'h000}, txn);
        chk("full_speed", 64'h0, lows);
        wait_req(1'b0, t1);
        repeat (3) @(posedge clk);
        chk("irq_masked", 64'h0, irq);
        apb(1'b1, sid_pkg::ADDR_INT_MASK, 32'h7);
        @(negedge clk);
        chk("irq_unmask", 64'h1, irq);
        finish_chk(32'h5);
        // every polling band but 16 microframes: two packets of 8, spacing in cycles of 8-cycle microframes
        for (int i = 0; i < 5; i++) begin
            d = desc(1'b0, 2'h0, 2'h3, 2'h0, 11'h008, 15'h0010);
            start(d, pcode[i]);
            wait_req(1'b1, t0);
            wait_req(1'b0, t1);
            wait_req(1'b1, t1);
            chk("interval_band", 64'(ufr[i] * 8), 64'(t1 - t0));
            wait_req(1'b0, t1);
            finish_chk(32'h5);
        end
        // bad kind, bad token, oversize total: refused at once
        for (int i = 0; i < 3; i++) begin
            d = desc(1'b1, 2'h0, i == 0 ? 2'h2 : 2'h3, i == 1 ? 2'h3 : 2'h1, 11'h040,
                i == 2 ? 15'h1001 : 15'h0010);
            start(d, 8'h00);
            finish_chk(32'h2);
        end
        // fatal answer from the far side ends the descriptor
        fatal_mode <= 1'b1;
        d = desc(1'b1, 2'h0, 2'h3, 2'h1, 11'h040, 15'h0100);
        start(d, 8'h00);
        wait_req(1'b1, t0);
        chk("full_speed_split", 64'h0, lows);
        wait_req(1'b0, t1);
        finish_chk(32'h2);
        give_verdict();
    end
endmodule : sid_split_intr_tb_top
`default_nettype wire
